// ==== src/tdmac_pkg.sv ====
// tdmac_pkg: constants, register map and state codes of the ten-channel dma
// assumes: one 200 MHz clock domain, 8-bit register address, 32-bit register data
package tdmac_pkg;
    // =====================================================================
    // sizes
    localparam int NCH = 10;
    localparam int RAW = 8;
    localparam int RDW = 32;
    localparam int MAW = 16;
    localparam int MDW = 16;
    localparam int CW = 8;
    localparam int NPER = 3;
    // =====================================================================
    // register map: channel c sits at c * 16 plus the offset below
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SRC = 4'h4;
    localparam logic [3:0] OFS_DST = 4'h8;
    localparam logic [3:0] OFS_CNT = 4'hC;
    localparam logic [7:0] REG_IRQ_STAT = 8'hA0;
    localparam logic [7:0] REG_IRQ_MASK = 8'hA4;
    localparam logic [7:0] REG_SWREQ = 8'hA8;
    localparam logic [7:0] REG_ENGINE = 8'hAC;
    // =====================================================================
    // channel control bit positions
    localparam int CTL_RING = 0;
    localparam int CTL_PEND = 1;
    localparam int CTL_SEL = 2;
    localparam int CTL_EN = 4;
    localparam int CTL_BYTE = 5;
    localparam int CTL_SINC = 6;
    localparam int CTL_DINC = 7;
    // request source select codes
    localparam logic [1:0] SEL_SW = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_C = 2'h3;
    // channels whose code 3 means one completed transfer of the preceding channel in their ring or chain
    localparam logic [NCH-1:0] CASC_MASK = 10'h2F6;
    // =====================================================================
    // transfer window and address stepping
    localparam logic [31:0] WINDOW_BASE = 32'h0080_0000;
    localparam int RING_BITS = 6;
    localparam logic [MAW-1:0] STEP_BYTE = 16'h0001;
    localparam logic [MAW-1:0] STEP_HALF = 16'h0002;
    localparam logic [CW-1:0] CNT_ZERO = 8'h00;
    localparam logic [CW-1:0] CNT_ONE = 8'h01;
    // one transfer takes three cycles with no wait states
    localparam int CYCLES_PER_XFER = 3;
    // =====================================================================
    typedef enum logic [1:0] {
        TD_IDLE = 2'b00,
        TD_READ = 2'b01,
        TD_WRITE = 2'b10
    } tdmac_state_t;
endpackage

// ==== src/tdmac_top.sv ====
// tdmac_top: ten-channel single-transfer dual-address dma engine with registers
// assumes: peripheral request pulses and memory ready come from the same clock
//
// Behaviour
// - ten channels, own source, setup, count
// - moves between addresses inside the 16-bit window at WINDOW_BASE
// - start by software or peripheral request
// - count allows up to 256 transfers
// - 16-bit window offsets, 8 or 16 bit items
// - read then write; bus released each transfer
// - addresses fixed, incrementing or ring wrapping
// - lowest numbered pending enabled channel served first
// - three cycles per transfer sustains rate
// - count underflow raises group interrupt
// - cascade ring over channels 0, 1, 2
// - channel 3 completion requests channel 4
// - cascade ring over channels 5, 6, 7
// - channel 8 completion requests channel 9
// - channel 0 underflow requests channel 5
// - pending flag: write zero clears, one keeps
// - channel 0 source codes 00..11 as listed
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module tdmac_top (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [tdmac_pkg::RAW-1:0] reg_addr_i,
    input wire logic [tdmac_pkg::RDW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [tdmac_pkg::RDW-1:0] reg_rdata_o,
    input wire logic [tdmac_pkg::NCH*tdmac_pkg::NPER-1:0] periph_req_i,
    output logic [31:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_byte_o,
    output logic [tdmac_pkg::MDW-1:0] mem_wdata_o,
    input wire logic [tdmac_pkg::MDW-1:0] mem_rdata_i,
    input wire logic mem_ready_i,
    output logic bus_busy_o,
    output logic irq_o
);
    import tdmac_pkg::*;

    // =====================================================================
    // channel state
    logic [NCH-1:0] ring_r, ring_nxt, pend_r, pend_nxt, en_r, en_nxt;
    logic [NCH-1:0] byte_r, byte_nxt, sinc_r, sinc_nxt, dinc_r, dinc_nxt;
    logic [NCH-1:0][1:0] sel_r, sel_nxt;
    logic [NCH-1:0][MAW-1:0] sa_r, sa_nxt, da_r, da_nxt;
    logic [NCH-1:0][CW-1:0] cnt_r, cnt_nxt;
    logic [NCH-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic irq_r, irq_nxt;
    logic [RDW-1:0] rdata_r, rdata_nxt;

    // engine state
    tdmac_state_t state_r, state_nxt;
    logic [3:0] act_r, act_nxt;
    logic [31:0] maddr_r, maddr_nxt;
    logic mrd_r, mrd_nxt, mwr_r, mwr_nxt, mbyte_r, mbyte_nxt, busy_r, busy_nxt;
    logic [MDW-1:0] data_r, data_nxt;

    // events of the current cycle
    logic [NCH-1:0] done, uflow, grant, chain_done, req, eligible;
    logic [3:0] win;
    logic any_elig;

    // =====================================================================
    // address stepping
    function automatic logic [MAW-1:0] step_addr(input logic [MAW-1:0] a,
            input logic inc, input logic ring, input logic bsz);
        logic [MAW-1:0] s;
        s = a + (bsz ? STEP_BYTE : STEP_HALF);
        if (!inc) begin
            step_addr = a;
        end else if (ring) begin
            // wrap inside an aligned block so the window is never left
            step_addr = {a[MAW-1:RING_BITS], s[RING_BITS-1:0]};
        end else begin
            step_addr = s;
        end
    endfunction

    // =====================================================================
    // request sources and cascades
    assign chain_done = {done[8], 1'b0, done[6], done[5], done[7],
                         done[3], 1'b0, done[1], done[0], 1'b0};

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            case (sel_r[c])
                SEL_SW: begin
                    // channel 0 code 00 also takes one channel 2 completion
                    req[c] = (c == 0) ? done[2] : 1'b0;
                end
                SEL_A: begin
                    req[c] = periph_req_i[c*NPER];
                end
                SEL_B: begin
                    req[c] = (c == 5) ? uflow[0] : periph_req_i[c*NPER+1];
                end
                SEL_C: begin
                    req[c] = CASC_MASK[c] ? chain_done[c] : periph_req_i[c*NPER+2];
                end
                default: begin
                    req[c] = 1'b0;
                end
            endcase
            if (reg_wr_i && reg_addr_i == REG_SWREQ && sel_r[c] == SEL_SW) begin
                req[c] = req[c] | reg_wdata_i[c];
            end
        end
    end

    // =====================================================================
    // fixed priority: lowest index wins
    assign eligible = pend_r & en_r;
    always_comb begin
        win = 4'h0;
        any_elig = 1'b0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (eligible[c]) begin
                win = 4'(c);
                any_elig = 1'b1;
            end
        end
    end

    // =====================================================================
    // transfer engine
    always_comb begin
        state_nxt = state_r;
        act_nxt = act_r;
        maddr_nxt = maddr_r;
        mrd_nxt = mrd_r;
        mwr_nxt = mwr_r;
        mbyte_nxt = mbyte_r;
        busy_nxt = busy_r;
        data_nxt = data_r;
        grant = '0;
        done = '0;
        uflow = '0;
        case (state_r)
            TD_IDLE: begin
                // one idle cycle between transfers hands the bus back
                if (any_elig) begin
                    grant[win] = 1'b1;
                    act_nxt = win;
                    maddr_nxt = WINDOW_BASE | {16'h0000, sa_r[win]};
                    mbyte_nxt = byte_r[win];
                    mrd_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    state_nxt = TD_READ;
                end
            end
            TD_READ: begin
                if (mem_ready_i) begin
                    data_nxt = mbyte_r ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i;
                    maddr_nxt = WINDOW_BASE | {16'h0000, da_r[act_r]};
                    mrd_nxt = 1'b0;
                    mwr_nxt = 1'b1;
                    state_nxt = TD_WRITE;
                end
            end
            TD_WRITE: begin
                if (mem_ready_i) begin
                    mwr_nxt = 1'b0;
                    busy_nxt = 1'b0;
                    done[act_r] = 1'b1;
                    uflow[act_r] = (cnt_r[act_r] == CNT_ZERO);
                    state_nxt = TD_IDLE;
                end
            end
            default: begin
                state_nxt = TD_IDLE;
                mrd_nxt = 1'b0;
                mwr_nxt = 1'b0;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= TD_IDLE;
            act_r <= 4'h0;
            maddr_r <= 32'h0000_0000;
            mrd_r <= 1'b0;
            mwr_r <= 1'b0;
            mbyte_r <= 1'b0;
            busy_r <= 1'b0;
            data_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            act_r <= act_nxt;
            maddr_r <= maddr_nxt;
            mrd_r <= mrd_nxt;
            mwr_r <= mwr_nxt;
            mbyte_r <= mbyte_nxt;
            busy_r <= busy_nxt;
            data_r <= data_nxt;
        end
    end

    // =====================================================================
    // channel registers: software writes first, engine updates override
    always_comb begin
        ring_nxt = ring_r;
        pend_nxt = pend_r;
        en_nxt = en_r;
        byte_nxt = byte_r;
        sinc_nxt = sinc_r;
        dinc_nxt = dinc_r;
        sel_nxt = sel_r;
        sa_nxt = sa_r;
        da_nxt = da_r;
        cnt_nxt = cnt_r;
        for (int c = 0; c < NCH; c++) begin
            if (reg_wr_i && reg_addr_i[7:4] == 4'(c)) begin
                case (reg_addr_i[3:0])
                    OFS_CTRL: begin
                        ring_nxt[c] = reg_wdata_i[CTL_RING];
                        // only a zero acts on the pending flag
                        pend_nxt[c] = pend_r[c] & reg_wdata_i[CTL_PEND];
                        sel_nxt[c] = reg_wdata_i[CTL_SEL+:2];
                        en_nxt[c] = reg_wdata_i[CTL_EN];
                        byte_nxt[c] = reg_wdata_i[CTL_BYTE];
                        sinc_nxt[c] = reg_wdata_i[CTL_SINC];
                        dinc_nxt[c] = reg_wdata_i[CTL_DINC];
                    end
                    OFS_SRC: begin
                        sa_nxt[c] = reg_wdata_i[MAW-1:0];
                    end
                    OFS_DST: begin
                        da_nxt[c] = reg_wdata_i[MAW-1:0];
                    end
                    OFS_CNT: begin
                        cnt_nxt[c] = reg_wdata_i[CW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (grant[c]) begin
                pend_nxt[c] = 1'b0;
            end
            if (done[c]) begin
                sa_nxt[c] = step_addr(sa_r[c], sinc_r[c], ring_r[c], byte_r[c]);
                da_nxt[c] = step_addr(da_r[c], dinc_r[c], ring_r[c], byte_r[c]);
                cnt_nxt[c] = cnt_r[c] - CNT_ONE;
            end
            if (uflow[c]) begin
                en_nxt[c] = 1'b0;
            end
            // a request on a live channel wins over a clear in the same cycle
            if (req[c] && en_r[c]) begin
                pend_nxt[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ring_r <= '0;
            pend_r <= '0;
            en_r <= '0;
            byte_r <= '0;
            sinc_r <= '0;
            dinc_r <= '0;
            sel_r <= '0;
            sa_r <= '0;
            da_r <= '0;
            cnt_r <= '0;
        end else begin
            ring_r <= ring_nxt;
            pend_r <= pend_nxt;
            en_r <= en_nxt;
            byte_r <= byte_nxt;
            sinc_r <= sinc_nxt;
            dinc_r <= dinc_nxt;
            sel_r <= sel_nxt;
            sa_r <= sa_nxt;
            da_r <= da_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // =====================================================================
    // interrupt: sticky underflow status, write one to clear, set wins
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (reg_wr_i && reg_addr_i == REG_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~reg_wdata_i[NCH-1:0];
        end
        if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) begin
            irq_mask_nxt = reg_wdata_i[NCH-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | uflow;
        irq_nxt = |(irq_stat_r & irq_mask_r);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // =====================================================================
    // register read: data only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == REG_IRQ_STAT) begin
                rdata_nxt[NCH-1:0] = irq_stat_r;
            end else if (reg_addr_i == REG_IRQ_MASK) begin
                rdata_nxt[NCH-1:0] = irq_mask_r;
            end else if (reg_addr_i == REG_ENGINE) begin
                rdata_nxt[5:0] = {busy_r, state_r == TD_WRITE, act_r};
            end else begin
                for (int c = 0; c < NCH; c++) begin
                    if (reg_addr_i[7:4] == 4'(c)) begin
                        case (reg_addr_i[3:0])
                            OFS_CTRL: begin
                                rdata_nxt[7:0] = {dinc_r[c], sinc_r[c], byte_r[c], en_r[c],
                                                  sel_r[c], pend_r[c], ring_r[c]};
                            end
                            OFS_SRC: begin
                                rdata_nxt[MAW-1:0] = sa_r[c];
                            end
                            OFS_DST: begin
                                rdata_nxt[MAW-1:0] = da_r[c];
                            end
                            OFS_CNT: begin
                                rdata_nxt[CW-1:0] = cnt_r[c];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // =====================================================================
    // outputs straight from flops
    assign reg_rdata_o = rdata_r;
    assign mem_addr_o = maddr_r;
    assign mem_rd_o = mrd_r;
    assign mem_wr_o = mwr_r;
    assign mem_byte_o = mbyte_r;
    assign mem_wdata_o = data_r;
    assign bus_busy_o = busy_r;
    assign irq_o = irq_r;
endmodule

// ==== testbench/tdmac_sva.sv ====
// tdmac_sva: port-level checks of the dma engine's memory and register sides
// assumes: bound to tdmac_top, one clock domain, reset active low
`timescale 1ns/1ps
module tdmac_sva
    import tdmac_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic reg_rd_i,
    input wire logic [tdmac_pkg::RDW-1:0] reg_rdata_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic mem_byte_o,
    input wire logic [tdmac_pkg::MDW-1:0] mem_wdata_o,
    input wire logic mem_ready_i,
    input wire logic bus_busy_o
);
    // =====================================================================
    // properties
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_rd_hold;
        mem_rd_o && !mem_ready_i |=> mem_rd_o && $stable(mem_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request dropped early");

    property p_wr_hold;
        mem_wr_o && !mem_ready_i |=> mem_wr_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request dropped early");

    property p_rd_then_wr;
        mem_rd_o && mem_ready_i |=> mem_wr_o && !mem_rd_o;
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) else $error("no write after read");

    property p_release;
        mem_wr_o && mem_ready_i |=> !mem_wr_o && !mem_rd_o && !bus_busy_o;
    endproperty
    a_release: assert property (p_release) else $error("bus kept after transfer");

    property p_window;
        mem_rd_o || mem_wr_o |-> mem_addr_o[31:16] == WINDOW_BASE[31:16];
    endproperty
    a_window: assert property (p_window) else $error("address outside window");

    property p_one_dir;
        mem_rd_o |-> !mem_wr_o && bus_busy_o;
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("read without bus or with write");

    property p_byte_zext;
        mem_wr_o && mem_byte_o |-> mem_wdata_o[15:8] == 8'h00;
    endproperty
    a_byte_zext: assert property (p_byte_zext) else $error("byte item not zero extended");

    property p_idle_gap;
        $rose(mem_rd_o) |-> !$past(bus_busy_o);
    endproperty
    a_idle_gap: assert property (p_idle_gap) else $error("no idle cycle between transfers");

    property p_rdata_zero;
        !reg_rd_i |=> reg_rdata_o == '0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside read slot");
endmodule

// ==== testbench/tdmac_mem.sv ====
// tdmac_mem: memory partner answering the engine's read/write port
// assumes: same clock as the engine; word at offset o is o xor KEY
`timescale 1ns/1ps
module tdmac_mem #(
    parameter logic [15:0] KEY = 16'h0000
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [31:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic [15:0] rdata_o,
    output logic ready_o
);
    logic tick_r;
    logic [15:0] word;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= ~tick_r;
        end
    end
    // slow mode adds a wait state every other cycle, stall holds the engine
    assign ready_o = (rd_i || wr_i) && !stall_i && (!slow_i || tick_r);
    assign word = addr_i[15:0] ^ KEY;
    // full word always returned: the engine must drop the upper lane itself
    assign rdata_o = rd_i ? word : ~word;
endmodule

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for the ten-channel dma engine
// assumes: tdmac_mem answers the memory port, tdmac_sva bound below
`timescale 1ns/1ps
module tb_top;
    import tdmac_pkg::*;
    localparam logic [15:0] KEY = 16'hC35A;
    localparam int PAIRS [8][2] = '{'{0, 1}, '{1, 2}, '{2, 0}, '{3, 4}, '{5, 6}, '{6, 7},
                                   '{7, 5}, '{8, 9}};
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [RAW-1:0] reg_addr_i = '0;
    logic [RDW-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [RDW-1:0] reg_rdata_o;
    logic [NCH*NPER-1:0] periph_req_i = '0;
    logic [31:0] mem_addr_o;
    logic mem_rd_o;
    logic mem_wr_o;
    logic mem_byte_o;
    logic [MDW-1:0] mem_wdata_o;
    logic [MDW-1:0] mem_rdata_i;
    logic mem_ready_i;
    logic bus_busy_o;
    logic irq_o;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [47:0] exp_q[$];
    logic [15:0] s;
    logic [15:0] d;
    int n_fail = 0;
    int n_compared = 0;

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    tdmac_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .periph_req_i(periph_req_i), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_byte_o(mem_byte_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ready_i(mem_ready_i),
        .bus_busy_o(bus_busy_o), .irq_o(irq_o));
    tdmac_mem #(.KEY(KEY)) u_mem (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(mem_addr_o),
        .rd_i(mem_rd_o), .wr_i(mem_wr_o), .stall_i(stall), .slow_i(slow),
        .rdata_o(mem_rdata_i), .ready_o(mem_ready_i));

    // =====================================================================
    // tasks
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [47:0] next_exp();
        return exp_q.size() != 0 ? exp_q.pop_front() : 48'hX;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        check("register", 48'(reg_rdata_o), 48'(e));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    // programs a channel and notes the n writes it should produce
    task automatic setup(input int c, input logic [7:0] cnt, input logic [7:0] ctl, input int n);
        logic [15:0] st;
        logic [15:0] sa;
        logic [15:0] da;
        st = ctl[CTL_BYTE] ? STEP_BYTE : STEP_HALF;
        s = 16'($urandom) & 16'h7FFE;
        d = 16'($urandom) & 16'hFFFC | 16'h8000;
        wr(8'(c * 16) | 8'(OFS_SRC), 32'(s));
        wr(8'(c * 16) | 8'(OFS_DST), 32'(d));
        wr(8'(c * 16) | 8'(OFS_CNT), 32'(cnt));
        wr(8'(c * 16), 32'(ctl));
        for (int i = 0; i < n; i++) begin
            sa = ctl[CTL_SINC] ? s + 16'(i) * st : s;
            da = ctl[CTL_DINC] ? d + 16'(i) * st : d;
            if (ctl[CTL_RING]) begin
                sa = {s[15:6], sa[5:0]};
                da = {d[15:6], da[5:0]};
            end
            sa = ctl[CTL_BYTE] ? {8'h00, sa[7:0] ^ KEY[7:0]} : sa ^ KEY;
            exp_q.push_back({WINDOW_BASE | 32'(da), sa});
        end
    endtask
    task automatic settle();
        for (int i = 0; i < 400 && (exp_q.size() != 0 || bus_busy_o !== 1'b0); i++)
            @(posedge clock_i);
        repeat (3) @(posedge clock_i);
        check("left over", 48'(exp_q.size()), 48'h0);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // =====================================================================
    // scoreboard: every accepted write takes the oldest note
    always @(posedge clock_i) begin
        if (resetn_i && mem_wr_o && mem_ready_i) begin
            check("transfer", {mem_addr_o, mem_wdata_o}, next_exp());
        end
    end

    initial begin
        #300000;
        n_fail++;
        print_verdict();
    end

    // =====================================================================
    // tests
    initial begin
        void'($urandom(32'h57AAEAF9));
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int c = 0; c < NCH; c++) rd(8'(c * 16), 32'h0);
        rd(8'hB0, 32'h0);
        $display("test reset done");
        for (int c = 0; c < NCH; c++) begin
            slow <= c[0];
            setup(c, 8'h00, 8'h50, 1);
            wr(REG_SWREQ, 32'(1) << c);
            settle();
            rd(8'(c * 16), 32'h40);
            rd(8'(c * 16) | 8'(OFS_SRC), 32'(s + 16'h2));
            rd(8'(c * 16) | 8'(OFS_DST), 32'(d));
            check("irq", 48'(irq_o), 48'h0);
        end
        rd(REG_IRQ_STAT, 32'h3FF);
        wr(REG_IRQ_MASK, 32'h8);
        rd(REG_IRQ_MASK, 32'h8);
        tick(2);
        check("irq", 48'(irq_o), 48'h1);
        wr(REG_IRQ_STAT, 32'h3FF);
        tick(2);
        check("irq", 48'(irq_o), 48'h0);
        $display("test single done");
        // full run of 256 byte items, ring wrapping on both sides
        setup(4, 8'hFF, 8'hF1, 256);
        // all 256 notes are queued up front, so only wait out each transfer here
        for (int i = 0; i < 256; i++) begin
            if (i == 255) rd(REG_IRQ_STAT, 32'h0);
            wr(REG_SWREQ, 32'h10);
            tick(8);
        end
        settle();
        rd(REG_IRQ_STAT, 32'h10);
        wr(REG_IRQ_STAT, 32'h10);
        $display("test count done");
        // ch0 and ch3 together: ch0, its cascade ch1, ch3, then ch5 by underflow
        setup(0, 8'h00, 8'h10, 1);
        setup(1, 8'h00, 8'h1C, 1);
        setup(2, 8'h00, 8'h0C, 0);
        setup(3, 8'h00, 8'h10, 1);
        setup(5, 8'h00, 8'h18, 1);
        wr(REG_SWREQ, 32'h9);
        settle();
        $display("test priority done");
        for (int k = 0; k < 8; k++) begin
            setup(PAIRS[k][0], 8'h00, 8'h10, 1);
            setup(PAIRS[k][1], 8'h00, PAIRS[k][1] == 0 ? 8'h10 : 8'h1C, 1);
            wr(REG_SWREQ, 32'(1) << PAIRS[k][0]);
            settle();
        end
        $display("test cascade done");
        for (int code = 1; code < 4; code++) begin
            setup(0, 8'h00, 8'(8'h10 | code << CTL_SEL), 1);
            @(posedge clock_i);
            periph_req_i <= 30'($urandom) & ~30'h7 | 30'(1) << (code - 1);
            @(posedge clock_i);
            periph_req_i <= '0;
            settle();
        end
        $display("test peripheral done");
        // engine held by a stalled read while flags are written
        stall <= 1'b1;
        setup(0, 8'h00, 8'h10, 1);
        setup(8, 8'h00, 8'h10, 1);
        setup(9, 8'h00, 8'h10, 0);
        setup(6, 8'h00, 8'h00, 0);
        wr(REG_SWREQ, 32'h341);
        wr(8'h80, 32'h12);
        rd(8'h80, 32'h12);
        wr(8'h90, 32'h10);
        rd(8'h90, 32'h10);
        rd(8'h60, 32'h0);
        rd(REG_ENGINE, 32'h20);
        @(posedge clock_i);
        stall <= 1'b0;
        settle();
        $display("test pending done");
        print_verdict();
    end
endmodule

bind tdmac_top tdmac_sva u_sva (.clock_i(clock_i), .resetn_i(resetn_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_byte_o(mem_byte_o), .mem_wdata_o(mem_wdata_o),
    .mem_ready_i(mem_ready_i), .bus_busy_o(bus_busy_o));
